// ===== src/sls_action.sv
// Action decoder: turns the raised condition into warning and fault outputs
`timescale 1ns/1ps
module sls_action (
  input  wire logic               active,
  input  wire sls_pkg::sls_action_t sel,
  input  wire logic               running,
  output logic                    warn,
  output logic                    fault
);
  import sls_pkg::*;
  assign warn  = active && (sel == SLS_ACT_WARNING);
  assign fault = active && ((sel == SLS_ACT_FAULT) ||
                            (sel == SLS_ACT_FAULT_RUN && running));
endmodule

// ===== src/sls_pkg.sv
// Package of constants and types for the signal limit supervisor
// Summary of operation
// - One hysteresis setting per channel, reset to zero, widens the thresholds in every comparison mode.
// - The mode selector decides how the monitored signal is compared with the low and high limits.
// - A separate action selector decides what the raised condition turns into.
// - Mode 0, the reset value, keeps the channel inactive and never raises the condition.
// - Mode 1 raises below low minus half hysteresis and clears above low plus half hysteresis.
// - Mode 2 raises above high plus half hysteresis and clears below high minus half hysteresis.
// - Mode 3 applies the low test to magnitudes of signal and low limit.
// - Mode 4 applies the high test to magnitudes of signal and high limit.
// - Mode 5 raises outside the widened low-high band and clears inside the narrowed band.
// - Mode 6 does the two-sided test on magnitudes.
// - The action code is 0 none, 1 warning, 2 fault, 3 fault only while running.
// - Mode 7 raises above high plus half hysteresis, clears below low minus half hysteresis, holds between.
package sls_pkg;

  localparam int SLS_DW = 32;
  localparam int SLS_TW = SLS_DW + 2;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SLS_OFF_MODE   = 8'h00;
  localparam logic [7:0] SLS_OFF_ACTION = 8'h04;
  localparam logic [7:0] SLS_OFF_LOW    = 8'h08;
  localparam logic [7:0] SLS_OFF_HIGH   = 8'h0c;
  localparam logic [7:0] SLS_OFF_HYST   = 8'h10;
  localparam logic [7:0] SLS_OFF_STATUS = 8'h14;
  localparam logic [7:0] SLS_OFF_IRQST  = 8'h18;
  localparam logic [7:0] SLS_OFF_IRQMSK = 8'h1c;
  localparam logic [7:0] SLS_OFF_SIGNAL = 8'h20;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]        SLS_RST_MODE   = 3'h0;
  localparam logic [1:0]        SLS_RST_ACTION = 2'h0;
  localparam logic [SLS_DW-1:0] SLS_RST_LIMIT  = 32'h0000_0000;
  localparam logic [SLS_DW-1:0] SLS_RST_HYST   = 32'h0000_0000;
  localparam logic [2:0]        SLS_RST_IRQMSK = 3'h0;

  // Interrupt status bit positions
  localparam int SLS_IRQ_RAISE = 0;
  localparam int SLS_IRQ_CLEAR = 1;
  localparam int SLS_IRQ_TRIP  = 2;

  typedef enum logic [2:0] {
    SLS_MODE_DISABLED = 3'h0,
    SLS_MODE_LOW      = 3'h1,
    SLS_MODE_HIGH     = 3'h2,
    SLS_MODE_ABS_LOW  = 3'h3,
    SLS_MODE_ABS_HIGH = 3'h4,
    SLS_MODE_BOTH     = 3'h5,
    SLS_MODE_ABS_BOTH = 3'h6,
    SLS_MODE_HYST     = 3'h7
  } sls_mode_t;

  typedef enum logic [1:0] {
    SLS_ACT_NONE      = 2'h0,
    SLS_ACT_WARNING   = 2'h1,
    SLS_ACT_FAULT     = 2'h2,
    SLS_ACT_FAULT_RUN = 2'h3
  } sls_action_t;

endpackage

// ===== src/sls_threshold.sv
// Threshold pair builder: limit plus and minus half hysteresis, optionally on magnitudes
`timescale 1ns/1ps
module sls_threshold #(
  parameter int DW = 32
) (
  input  wire logic signed [DW-1:0] limit,
  input  wire logic        [DW-1:0] hyst,
  input  wire logic                 use_abs,
  output logic signed      [DW+1:0] thr_up,
  output logic signed      [DW+1:0] thr_dn
);
  // Two guard bits keep magnitude of the most negative limit plus half hysteresis exact
  wire logic signed [DW+1:0] lim_ext  = {{2{limit[DW-1]}}, limit};
  wire logic signed [DW+1:0] lim_mag  = (use_abs && limit[DW-1]) ? -lim_ext : lim_ext;
  wire logic signed [DW+1:0] half_h   = $signed({3'b000, hyst[DW-1:1]});

  assign thr_up = lim_mag + half_h;
  assign thr_dn = lim_mag - half_h;
endmodule

// ===== src/sls_top.sv
// Signal limit supervisor channel with Wishbone register access
`timescale 1ns/1ps
module sls_top (
  input  wire logic                            clock,
  input  wire logic                            sys_rst,
  input  wire logic [sls_pkg::SLS_DW-1:0]      sample,
  input  wire logic                            running,
  input  wire logic [7:0]                      wb_adr_i,
  input  wire logic [31:0]                     wb_dat_i,
  input  wire logic [3:0]                      wb_sel_i,
  input  wire logic                            wb_we_i,
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  output logic      [31:0]                     wb_dat_o,
  output logic                                 wb_ack_o,
  output logic                                 wb_err_o,
  output logic                                 cond_out,
  output logic                                 warn_out,
  output logic                                 fault_out,
  output logic                                 irq
);
  import sls_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  sls_mode_t          mode_r;
  sls_action_t        action_r;
  logic [SLS_DW-1:0]  low_r;
  logic [SLS_DW-1:0]  high_r;
  logic [SLS_DW-1:0]  hyst_r;
  logic [2:0]         irq_st_r;
  logic [2:0]         irq_msk_r;
  logic               cond_r;
  logic               cond_nxt;
  logic               ack_r;
  logic               err_r;
  logic [31:0]        rdat_r;
  logic [31:0]        rdat_nxt;
  logic               fault_d_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic req      = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
  wire logic wr_all   = req && wb_we_i && (wb_sel_i == 4'hf);
  wire logic hit_mode = wb_adr_i == SLS_OFF_MODE;
  wire logic hit_act  = wb_adr_i == SLS_OFF_ACTION;
  wire logic hit_low  = wb_adr_i == SLS_OFF_LOW;
  wire logic hit_high = wb_adr_i == SLS_OFF_HIGH;
  wire logic hit_hyst = wb_adr_i == SLS_OFF_HYST;
  wire logic hit_stat = wb_adr_i == SLS_OFF_STATUS;
  wire logic hit_ist  = wb_adr_i == SLS_OFF_IRQST;
  wire logic hit_imsk = wb_adr_i == SLS_OFF_IRQMSK;
  wire logic hit_sig  = wb_adr_i == SLS_OFF_SIGNAL;
  wire logic mapped   = hit_mode | hit_act | hit_low | hit_high | hit_hyst |
                        hit_stat | hit_ist | hit_imsk | hit_sig;

  // ----------------------------------------------------------------
  // Sample input synchroniser (signal comes from another block's pins)
  // ----------------------------------------------------------------
  logic [SLS_DW-1:0] smp_meta_r;
  logic [SLS_DW-1:0] smp_r;
  logic              run_meta_r;
  logic              run_r;

  always_ff @(posedge clock) begin
    smp_meta_r <= sample;
    smp_r      <= smp_meta_r;
    run_meta_r <= running;
    run_r      <= run_meta_r;
  end

  // ----------------------------------------------------------------
  // Comparison
  // ----------------------------------------------------------------
  wire logic use_abs = (mode_r == SLS_MODE_ABS_LOW) || (mode_r == SLS_MODE_ABS_HIGH) ||
                       (mode_r == SLS_MODE_ABS_BOTH);
  logic signed [SLS_TW-1:0] low_up;
  logic signed [SLS_TW-1:0] low_dn;
  logic signed [SLS_TW-1:0] high_up;
  logic signed [SLS_TW-1:0] high_dn;

  sls_threshold #(.DW(SLS_DW)) u_thr_low (
    .limit   ($signed(low_r)),
    .hyst    (hyst_r),
    .use_abs (use_abs),
    .thr_up  (low_up),
    .thr_dn  (low_dn)
  );

  sls_threshold #(.DW(SLS_DW)) u_thr_high (
    .limit   ($signed(high_r)),
    .hyst    (hyst_r),
    .use_abs (use_abs),
    .thr_up  (high_up),
    .thr_dn  (high_dn)
  );

  wire logic signed [SLS_TW-1:0] sig_ext = {{2{smp_r[SLS_DW-1]}}, smp_r};
  wire logic signed [SLS_TW-1:0] sig_v   = (use_abs && smp_r[SLS_DW-1]) ? -sig_ext : sig_ext;

  wire logic below_low_dn  = sig_v < low_dn;
  wire logic above_low_up  = sig_v > low_up;
  wire logic above_high_up = sig_v > high_up;
  wire logic below_high_dn = sig_v < high_dn;

  // One-sided modes hold between thresholds; the last assignment wins
  always_comb begin
    cond_nxt = cond_r;
    unique case (mode_r)
      SLS_MODE_DISABLED: cond_nxt = 1'b0;
      SLS_MODE_LOW, SLS_MODE_ABS_LOW: begin
        if (above_low_up) cond_nxt = 1'b0;
        if (below_low_dn) cond_nxt = 1'b1;
      end
      SLS_MODE_HIGH, SLS_MODE_ABS_HIGH: begin
        if (below_high_dn) cond_nxt = 1'b0;
        if (above_high_up) cond_nxt = 1'b1;
      end
      SLS_MODE_BOTH, SLS_MODE_ABS_BOTH: begin
        if (above_low_up && below_high_dn) cond_nxt = 1'b0;
        if (above_high_up || below_low_dn) cond_nxt = 1'b1;
      end
      SLS_MODE_HYST: begin
        if (below_low_dn)  cond_nxt = 1'b0;
        if (above_high_up) cond_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cond_r <= 1'b0;
    end else begin
      cond_r <= cond_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Action selection
  // ----------------------------------------------------------------
  logic warn_c;
  logic fault_c;

  sls_action u_action (
    .active  (cond_r),
    .sel     (action_r),
    .running (run_r),
    .warn    (warn_c),
    .fault   (fault_c)
  );

  assign cond_out  = cond_r;
  assign warn_out  = warn_c;
  assign fault_out = fault_c;

  // ----------------------------------------------------------------
  // Interrupt events: raise, clear, fault onset
  // ----------------------------------------------------------------
  wire logic [2:0] irq_ev = {fault_c && !fault_d_r, cond_r && !cond_nxt, !cond_r && cond_nxt};
  wire logic [2:0] irq_w1c = (wr_all && hit_ist) ? wb_dat_i[2:0] : 3'h0;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_st_r  <= 3'h0;
      fault_d_r <= 1'b0;
    end else begin
      // Set wins over a clear in the same cycle
      irq_st_r  <= (irq_st_r & ~irq_w1c) | irq_ev;
      fault_d_r <= fault_c;
    end
  end

  assign irq = |(irq_st_r & irq_msk_r);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Partial-lane writes are ignored: a half-written limit would glitch the comparator
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_r    <= sls_mode_t'(SLS_RST_MODE);
      action_r  <= sls_action_t'(SLS_RST_ACTION);
      low_r     <= SLS_RST_LIMIT;
      high_r    <= SLS_RST_LIMIT;
      hyst_r    <= SLS_RST_HYST;
      irq_msk_r <= SLS_RST_IRQMSK;
    end else if (wr_all) begin
      if (hit_mode) mode_r    <= sls_mode_t'(wb_dat_i[2:0]);
      if (hit_act)  action_r  <= sls_action_t'(wb_dat_i[1:0]);
      if (hit_low)  low_r     <= wb_dat_i;
      if (hit_high) high_r    <= wb_dat_i;
      if (hit_hyst && !wb_dat_i[31]) hyst_r <= wb_dat_i;
      if (hit_imsk) irq_msk_r <= wb_dat_i[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Read mux and acknowledge
  // ----------------------------------------------------------------
  always_comb begin
    rdat_nxt = 32'h0000_0000;
    if (hit_mode) rdat_nxt = {29'h0, mode_r};
    if (hit_act)  rdat_nxt = {30'h0, action_r};
    if (hit_low)  rdat_nxt = low_r;
    if (hit_high) rdat_nxt = high_r;
    if (hit_hyst) rdat_nxt = hyst_r;
    if (hit_stat) rdat_nxt = {29'h0, fault_c, warn_c, cond_r};
    if (hit_ist)  rdat_nxt = {29'h0, irq_st_r};
    if (hit_imsk) rdat_nxt = {29'h0, irq_msk_r};
    if (hit_sig)  rdat_nxt = smp_r;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ack_r  <= 1'b0;
      err_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r  <= req && mapped;
      err_r  <= req && !mapped;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;
  assign wb_dat_o = rdat_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_disabled_never_raises: assert property (@(posedge clock) disable iff (sys_rst)
    mode_r == SLS_MODE_DISABLED |=> !cond_r)
    else $error("condition raised while disabled");

  a_low_sets_cond: assert property (@(posedge clock) disable iff (sys_rst)
    (mode_r == SLS_MODE_LOW && below_low_dn) |=> cond_r)
    else $error("low mode did not raise");

  a_high_clears_cond: assert property (@(posedge clock) disable iff (sys_rst)
    (mode_r == SLS_MODE_HIGH && below_high_dn && !above_high_up) |=> !cond_r)
    else $error("high mode did not clear");

  a_abs_low_sets: assert property (@(posedge clock) disable iff (sys_rst)
    (mode_r == SLS_MODE_ABS_LOW && below_low_dn) |=> cond_r)
    else $error("abs low mode did not raise");

  a_abs_high_sets: assert property (@(posedge clock) disable iff (sys_rst)
    (mode_r == SLS_MODE_ABS_HIGH && above_high_up) |=> cond_r)
    else $error("abs high mode did not raise");

  a_both_band_clear: assert property (@(posedge clock) disable iff (sys_rst)
    (mode_r == SLS_MODE_BOTH && above_low_up && below_high_dn && !above_high_up && !below_low_dn)
      |=> !cond_r)
    else $error("both mode did not clear in band");

  a_hyst_mode_hold: assert property (@(posedge clock) disable iff (sys_rst)
    (mode_r == SLS_MODE_HYST && !below_low_dn && !above_high_up) |=> cond_r == $past(cond_r))
    else $error("hysteresis mode changed state in band");

  a_warn_follows_action: assert property (@(posedge clock) disable iff (sys_rst)
    warn_out == (cond_r && action_r == SLS_ACT_WARNING) && !(fault_out && action_r == SLS_ACT_NONE))
    else $error("action outputs disagree with selector");

  a_ack_one_cycle: assert property (@(posedge clock) disable iff (sys_rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_low_clears_cond: assert property (@(posedge clock) disable iff (sys_rst)
    (mode_r == SLS_MODE_LOW && above_low_up && !below_low_dn) |=> !cond_r)
    else $error("low mode did not clear");

  a_low_band_hold: assert property (@(posedge clock) disable iff (sys_rst)
    (mode_r == SLS_MODE_LOW && !below_low_dn && !above_low_up) |=> cond_r == $past(cond_r))
    else $error("low mode changed state in band");

  a_abs_both_sets: assert property (@(posedge clock) disable iff (sys_rst)
    (mode_r == SLS_MODE_ABS_BOTH && (above_high_up || below_low_dn)) |=> cond_r)
    else $error("abs both mode did not raise");

  a_abs_both_clear: assert property (@(posedge clock) disable iff (sys_rst)
    (mode_r == SLS_MODE_ABS_BOTH && above_low_up && below_high_dn && !above_high_up && !below_low_dn)
      |=> !cond_r)
    else $error("abs both mode did not clear in band");

  a_hyst_mode_sets: assert property (@(posedge clock) disable iff (sys_rst)
    (mode_r == SLS_MODE_HYST && above_high_up) |=> cond_r)
    else $error("hysteresis mode did not raise");

  a_hyst_mode_clears: assert property (@(posedge clock) disable iff (sys_rst)
    (mode_r == SLS_MODE_HYST && below_low_dn && !above_high_up) |=> !cond_r)
    else $error("hysteresis mode did not clear");

  a_fault_run_gate: assert property (@(posedge clock) disable iff (sys_rst)
    (action_r == SLS_ACT_FAULT_RUN && !run_r) |-> !fault_out)
    else $error("fault raised while stopped");

  a_irq_set_wins: assert property (@(posedge clock) disable iff (sys_rst)
    (irq_ev != 3'h0) |=> ((irq_st_r & $past(irq_ev)) == $past(irq_ev)))
    else $error("interrupt event lost");

  a_err_one_cycle: assert property (@(posedge clock) disable iff (sys_rst)
    wb_err_o |=> !wb_err_o)
    else $error("err held longer than one cycle");

  a_ack_err_excl: assert property (@(posedge clock) disable iff (sys_rst)
    !(wb_ack_o && wb_err_o))
    else $error("ack and err together");
endmodule

// ===== verif/sls_tb.sv
// Self-checking testbench for the signal limit supervisor channel
`timescale 1ns/1ps
module testbench;
  import sls_pkg::*;

  logic        clock;
  logic        sys_rst;
  logic [31:0] sample;
  logic        running;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0]  wb_sel_i;
  logic        wb_we_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        wb_err_o;
  logic        cond_out;
  logic        warn_out;
  logic        fault_out;
  logic        irq;
  logic [31:0] rd_q;
  logic        rd_e;
  int          error_cnt;
  int          n_tests;

  sls_top sls_top_inst (.clock(clock), .sys_rst(sys_rst), .sample(sample), .running(running),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .cond_out(cond_out), .warn_out(warn_out), .fault_out(fault_out), .irq(irq));

  // ----------------------------------------------------------------
  // Clock, reset, watchdog
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic single cycle; the answer is taken at the edge where ack or err is seen
  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w, input logic [3:0] s);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i  <= w;
    wb_sel_i <= s;
    do begin
      @(posedge clock);
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    chk_bit(wb_ack_o ^ wb_err_o, 1'b1);
    rd_q = wb_dat_o;
    rd_e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(a, d, 1'b1, 4'hf);
  endtask

  task automatic rd(input logic [7:0] a);
    wb(a, 32'h0000_0000, 1'b0, 4'hf);
  endtask

  // Sample goes through two sync flops and the compare stage before cond moves
  task automatic step(input int v, input logic e);
    @(posedge clock);
    sample <= 32'(v);
    repeat (6) @(posedge clock);
    chk_bit(cond_out, e);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] offs [8];
    offs = '{SLS_OFF_MODE, SLS_OFF_ACTION, SLS_OFF_LOW, SLS_OFF_HIGH,
             SLS_OFF_HYST, SLS_OFF_STATUS, SLS_OFF_IRQST, SLS_OFF_IRQMSK};
    foreach (offs[i]) begin
      rd(offs[i]);
      chk_word(rd_q, 32'h0000_0000);
    end
    rd(8'h40);
    chk_bit(rd_e, 1'b1);
    chk_bit(cond_out | warn_out | fault_out | irq, 1'b0);
  endtask

  task automatic t_disabled();
    wr(SLS_OFF_LOW, 32'd100);
    wr(SLS_OFF_HIGH, 32'd200);
    step(-1000, 1'b0);
    step(5000, 1'b0);
    rd(SLS_OFF_SIGNAL);
    chk_word(rd_q, 32'd5000);
  endtask

  // Zero hysteresis puts both thresholds on the limit itself
  task automatic t_hyst_default();
    wr(SLS_OFF_MODE, 32'(SLS_MODE_LOW));
    step(99, 1'b1);
    step(101, 1'b0);
  endtask

  task automatic t_refuse();
    wr(SLS_OFF_HYST, 32'h8000_0014);
    rd(SLS_OFF_HYST);
    chk_word(rd_q, 32'h0000_0000);
    wb(SLS_OFF_HYST, 32'h0000_0014, 1'b1, 4'h7);
    rd(SLS_OFF_HYST);
    chk_word(rd_q, 32'h0000_0000);
    wr(SLS_OFF_HYST, 32'h0000_0014);
    rd(SLS_OFF_HYST);
    chk_word(rd_q, 32'h0000_0014);
  endtask

  task automatic t_one_sided();
    step(95, 1'b0);
    step(89, 1'b1);
    step(95, 1'b1);
    step(111, 1'b0);
    wr(SLS_OFF_MODE, 32'(SLS_MODE_HIGH));
    step(205, 1'b0);
    step(211, 1'b1);
    step(195, 1'b1);
    step(189, 1'b0);
  endtask

  // Negative low limit: only its magnitude may count
  task automatic t_abs();
    wr(SLS_OFF_LOW, 32'hffff_ff9c);
    wr(SLS_OFF_MODE, 32'(SLS_MODE_ABS_LOW));
    step(-89, 1'b1);
    step(95, 1'b1);
    step(-111, 1'b0);
    wr(SLS_OFF_LOW, 32'd100);
    wr(SLS_OFF_MODE, 32'(SLS_MODE_ABS_HIGH));
    step(-211, 1'b1);
    step(-195, 1'b1);
    step(-189, 1'b0);
  endtask

  task automatic t_both();
    wr(SLS_OFF_MODE, 32'(SLS_MODE_BOTH));
    step(89, 1'b1);
    step(150, 1'b0);
    step(211, 1'b1);
    step(195, 1'b1);
    step(-150, 1'b1);
    step(150, 1'b0);
    wr(SLS_OFF_MODE, 32'(SLS_MODE_ABS_BOTH));
    step(-89, 1'b1);
    step(-150, 1'b0);
    step(-211, 1'b1);
    step(-150, 1'b0);
    wr(SLS_OFF_MODE, 32'(SLS_MODE_HYST));
    step(211, 1'b1);
    step(150, 1'b1);
    step(89, 1'b0);
    step(150, 1'b0);
  endtask

  task automatic t_action();
    logic [1:0] exp_wf [4];
    exp_wf = '{2'b00, 2'b01, 2'b10, 2'b00};
    wr(SLS_OFF_MODE, 32'(SLS_MODE_LOW));
    step(80, 1'b1);
    for (int a = 0; a < 4; a++) begin
      wr(SLS_OFF_ACTION, 32'(a));
      rd(SLS_OFF_STATUS);
      chk_word(rd_q, {29'h0, exp_wf[a], 1'b1});
      chk_bit(fault_out, exp_wf[a][1]);
      chk_bit(warn_out, exp_wf[a][0]);
    end
    running <= 1'b1;
    repeat (4) @(posedge clock);
    chk_bit(fault_out, 1'b1);
  endtask

  task automatic t_irq();
    chk_bit(irq, 1'b0);
    wr(SLS_OFF_IRQST, 32'h0000_0007);
    rd(SLS_OFF_IRQST);
    chk_word(rd_q, 32'h0000_0000);
    wr(SLS_OFF_IRQMSK, 32'h0000_0003);
    step(111, 1'b0);
    rd(SLS_OFF_IRQST);
    chk_word(rd_q, 32'h0000_0002);
    chk_bit(irq, 1'b1);
    wr(SLS_OFF_IRQST, 32'h0000_0002);
    @(posedge clock);
    chk_bit(irq, 1'b0);
    step(80, 1'b1);
    rd(SLS_OFF_IRQST);
    chk_word(rd_q, 32'h0000_0005);
    wr(SLS_OFF_IRQMSK, 32'h0000_0004);
    @(posedge clock);
    chk_bit(irq, 1'b1);
    wr(SLS_OFF_IRQST, 32'h0000_0005);
    @(posedge clock);
    chk_bit(irq, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    error_cnt = 0;
    n_tests   = 0;
    sys_rst   = 1'b1;
    sample    = 32'h0000_0000;
    running   = 1'b0;
    wb_adr_i  = 8'h00;
    wb_dat_i  = 32'h0000_0000;
    wb_sel_i  = 4'h0;
    wb_we_i   = 1'b0;
    wb_cyc_i  = 1'b0;
    wb_stb_i  = 1'b0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_disabled();
    t_hyst_default();
    t_refuse();
    t_one_sided();
    t_abs();
    t_both();
    t_action();
    t_irq();
    sys_rst <= 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    give_verdict();
  end
endmodule
